/* File: burst_sram_regs.svh */
// Purpose: Constants of the burst SRAM cycle decoder
// Assumes: Included by its bare name
// Notes: Defines only
`ifndef BURST_SRAM_REGS_SVH
`define BURST_SRAM_REGS_SVH
`define BURST_ADDR_W 18
`define BURST_LANES 4
`define BURST_LANE_W 8
`define BURST_CNT_W 2
`define BURST_CNT_RST 2'h0
`define BURST_CNT_STEP 2'h1
`endif

/* File: burst_sram_pkg.sv */
// Purpose: Types of the burst SRAM cycle decoder
// Assumes: Nothing
// Notes: Strobe fields are active low
package burst_sram_pkg;
    typedef enum logic [2:0] {
        cyc_deselect,
        cyc_sleep,
        cyc_begin_read,
        cyc_begin_write,
        cyc_next_read,
        cyc_next_write,
        cyc_hold_read,
        cyc_hold_write
    } cycle_t;

    typedef struct packed {
        logic primary_chip_select_n;
        logic depth_select_high;
        logic depth_select_low_n;
        logic processor_addr_strobe;
        logic controller_addr_strobe;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_master_n;
    } ctl_t;
endpackage : burst_sram_pkg

/* File: burst_sram_cycle_decode.sv */
// Purpose: Cycle decode, burst counter, byte writes and data pin control of a flow-through burst SRAM
// Assumes: Control, address and write data are synchronous to mclk; sleep and output enable are not
// Notes: Data pins are split into in, out and enable; enables are high while driving
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_regs.svh"

// Overview of operation
// R1: A processor strobe start with all enables active begins a burst read at the external address.
// R2: A processor strobe start cycle never writes; writes happen on later edges or on controller strobe starts.
// R3: A controller strobe start with all enables active and the processor strobe high writes or reads by the write qualifier.
// R4: Primary enable high with the controller strobe low, or a strobe low with a depth enable inactive, deselects.
// R5: Sleep high forces power down and tri-stated data pins regardless of every other input.
// R6: Inactive strobes with advance low read the next burst address, ignoring chip enables.
// R7: Inactive strobes with advance low and a write writes at the next burst address.
// R8: Inactive strobes with advance high read again at the current burst address.
// R9: Inactive strobes with advance high and a write writes at the current burst address.
// R10: Global write low writes all lanes; master byte write low writes only the selected lanes.
// R11: Global write high with master byte write high or all lane selects high is a read.
// R12: Data pins follow the current cycle type gated asynchronously by the output enable.
// R13: Output enable is masked during write cycles so the pins never drive then.
// R14: In a read cycle all bits drive when output enable is low, else or when deselected they float.
// R15: The bus master raises output enable before a write starts and may then leave it as it likes.
// R16: Any lane select combination is legal; each selected lane writes its byte and parity bit.
// R17: A two-bit wraparound counter cleared on a start and combined with the stored low address bits gives linear or interleaved order.
module burst_sram_cycle_decode
    import burst_sram_pkg::*;
#(
    parameter int ADDR_W = `BURST_ADDR_W,
    parameter int LANES = `BURST_LANES,
    parameter int LANE_W = `BURST_LANE_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire ctl_t ctl,
    input wire logic [LANES-1:0] byte_lane_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic burst_order,
    input wire logic sleep_request,
    input wire logic output_enable_n,
    input wire logic [LANES*LANE_W-1:0] data_in,
    output logic [LANES*LANE_W-1:0] data_out,
    output logic [LANES*LANE_W-1:0] data_oe,
    input wire logic [LANES-1:0] parity_io_in,
    output logic [LANES-1:0] parity_io_out,
    output logic [LANES-1:0] parity_io_oe
);
    localparam int WORD_W = LANES * (LANE_W + 1);

    logic [WORD_W-1:0] mem [2**ADDR_W];
    logic sleep_s1_q, sleep_s2_q;
    logic selected_q;
    cycle_t cyc, cyc_q;
    logic [ADDR_W-1:0] base_q;
    logic [`BURST_CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] addr_used;
    logic [LANES-1:0] lanes, wr_lanes;
    logic [WORD_W-1:0] rd_q;
    logic strobe_p, strobe_c, enables_ok, is_write, drive;

    // Burst order on the low address bits: interleaved when order is high
    function automatic logic [`BURST_CNT_W-1:0] burst_lo(input logic [`BURST_CNT_W-1:0] base,
                                                        input logic [`BURST_CNT_W-1:0] cnt,
                                                        input logic order);
        burst_lo = order ? (base ^ cnt) : (base + cnt); // R17
    endfunction : burst_lo

    // Sleep pin synchroniser for the cycle state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
        end else begin
            sleep_s1_q <= sleep_request;
            sleep_s2_q <= sleep_s1_q;
        end
    end

    // Processor strobe is ignored while the primary enable is high
    assign strobe_p = !ctl.processor_addr_strobe && !ctl.primary_chip_select_n;
    assign strobe_c = !ctl.controller_addr_strobe;
    assign enables_ok = !ctl.primary_chip_select_n && ctl.depth_select_high && !ctl.depth_select_low_n;

    always_comb begin
        if (!ctl.global_write_n) begin
            lanes = '1; // R10
        end else if (!ctl.byte_write_master_n) begin
            lanes = ~byte_lane_select_n; // R10 R16
        end else begin
            lanes = '0; // R11
        end
    end
    assign is_write = |lanes; // R11

    always_comb begin
        if (sleep_s2_q) begin
            cyc = cyc_sleep; // R5
        end else if ((ctl.primary_chip_select_n && strobe_c) ||
                     ((strobe_p || strobe_c) && !enables_ok)) begin
            cyc = cyc_deselect; // R4
        end else if (strobe_p) begin
            cyc = cyc_begin_read; // R1 R2
        end else if (strobe_c) begin
            cyc = is_write ? cyc_begin_write : cyc_begin_read; // R3
        end else if (!selected_q) begin
            cyc = cyc_deselect;
        end else if (!ctl.burst_advance_n) begin
            cyc = is_write ? cyc_next_write : cyc_next_read; // R6 R7
        end else begin
            cyc = is_write ? cyc_hold_write : cyc_hold_read; // R8 R9
        end
    end

    always_comb begin
        unique case (cyc)
            cyc_begin_read, cyc_begin_write: addr_used = addr;
            cyc_next_read, cyc_next_write: addr_used = {base_q[ADDR_W-1:`BURST_CNT_W],
                burst_lo(base_q[`BURST_CNT_W-1:0], cnt_q + `BURST_CNT_STEP, burst_order)}; // R6 R7
            default: addr_used = {base_q[ADDR_W-1:`BURST_CNT_W],
                burst_lo(base_q[`BURST_CNT_W-1:0], cnt_q, burst_order)}; // R8 R9
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cyc_q <= cyc_deselect;
            selected_q <= 1'b0;
        end else begin
            cyc_q <= cyc;
            selected_q <= (cyc != cyc_deselect) && (cyc != cyc_sleep);
        end
    end

    // Burst counter: load on a start, step on advance, hold on suspend
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            base_q <= '0;
            cnt_q <= `BURST_CNT_RST;
        end else if (cyc == cyc_begin_read || cyc == cyc_begin_write) begin
            base_q <= addr; // R17
            cnt_q <= `BURST_CNT_RST;
        end else if (cyc == cyc_next_read || cyc == cyc_next_write) begin
            cnt_q <= cnt_q + `BURST_CNT_STEP; // R6 R7 R17
        end
    end

    always_comb begin
        unique case (cyc)
            cyc_begin_write, cyc_next_write, cyc_hold_write: wr_lanes = lanes; // R2 R16
            default: wr_lanes = '0;
        endcase
    end

    // Each lane stores its data byte and its parity bit; one process owns the whole array
    always_ff @(posedge mclk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_lanes[i]) begin
                mem[addr_used][i*(LANE_W+1) +: LANE_W+1] <= {parity_io_in[i], data_in[i*LANE_W +: LANE_W]}; // R16
            end
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign data_out[g*LANE_W +: LANE_W] = rd_q[g*(LANE_W+1) +: LANE_W];
        assign parity_io_out[g] = rd_q[g*(LANE_W+1) + LANE_W];
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rd_q <= '0;
        end else if (cyc == cyc_begin_read || cyc == cyc_next_read || cyc == cyc_hold_read) begin
            rd_q <= mem[addr_used];
        end
    end

    // Output enable and sleep act without the clock
    always_comb begin
        unique case (cyc_q)
            cyc_begin_read, cyc_next_read, cyc_hold_read: drive = !output_enable_n && !sleep_request; // R12 R14 R5
            default: drive = 1'b0; // R13 R4
        endcase
    end
    assign data_oe = {(LANES*LANE_W){drive}}; // R12
    assign parity_io_oe = {LANES{drive}}; // R12

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_begin_write;
        !sleep_s2_q && enables_ok && ctl.processor_addr_strobe && strobe_c && is_write;
    endsequence
    sequence s_begin_proc;
        !sleep_s2_q && enables_ok && strobe_p;
    endsequence

    a_sleep_floats: assert property (sleep_request |-> (data_oe == '0) && (parity_io_oe == '0)) // R5
        else $error("data pins driven in sleep");
    a_proc_start_reads: assert property (s_begin_proc |=> cyc_q == cyc_begin_read) // R1
        else $error("processor start did not read");
    a_proc_no_write: assert property (s_begin_proc |-> wr_lanes == '0) // R2
        else $error("processor start wrote");
    a_ctrl_write_floats: assert property (s_begin_write |=> cyc_q == cyc_begin_write ##0 data_oe == '0) // R3 R13
        else $error("controller write start wrong");
    a_deselect_floats: assert property (!sleep_s2_q && ctl.primary_chip_select_n && strobe_c
        |=> !selected_q && data_oe == '0) // R4
        else $error("deselect not honoured");
    a_next_steps: assert property (cyc == cyc_next_read |=> cnt_q == $past(cnt_q) + `BURST_CNT_STEP) // R6
        else $error("burst address did not advance");
    a_hold_keeps: assert property (cyc == cyc_hold_write |=> $stable(cnt_q)) // R9
        else $error("suspended burst moved");
    a_begin_loads: assert property (s_begin_proc |=> base_q == $past(addr) && cnt_q == `BURST_CNT_RST) // R17
        else $error("burst counter not loaded");
    // Pins stay quiet through next and hold write cycles, whatever the output enable does
    a_write_masked: assert property ((cyc_q == cyc_next_write || cyc_q == cyc_hold_write) |-> data_oe == '0) // R13
        else $error("pins driven in a write");
    a_read_drives: assert property (cyc_q == cyc_next_read && !output_enable_n && !sleep_request
        |-> &data_oe) // R14
        else $error("read did not drive");
    a_lane_writes: assert property (cyc == cyc_hold_write && wr_lanes[0]
        |=> mem[$past(addr_used)][LANE_W:0] == $past({parity_io_in[0], data_in[LANE_W-1:0]})) // R16 R10
        else $error("lane write lost");
endmodule : burst_sram_cycle_decode
`default_nettype wire

/* File: host_bus_model.sv */
// Purpose: Bus master side of the shared data and parity pins
// Assumes: The master drives the pins only on write cycles
// Notes: Bits nobody drives show the inverse of their last level
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic mclk,
    input wire logic drv,
    input wire logic [35:0] wdat,
    input wire logic [35:0] dout,
    input wire logic [35:0] doe,
    output logic [35:0] bus,
    output logic [7:0] clash
);
    logic [35:0] last_q = 36'h0;
    logic [7:0] clash_q = 8'h0;
    assign clash = clash_q;
    assign bus = drv ? wdat : ((doe & dout) | (~doe & ~last_q));
    always_ff @(posedge mclk) begin
        last_q <= bus;
    end
    // Counts edges where both sides drive the pins
    always_ff @(posedge mclk) begin
        if (drv && doe != 36'h0) begin
            clash_q <= clash_q + 8'h1;
        end
    end
endmodule : host_bus_model
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench of the burst SRAM cycle decoder
// Assumes: Inputs change at the falling edge of mclk
// Notes: Words are packed as {parity, data}
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import burst_sram_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    ctl_t ctl = 8'hff;
    logic [3:0] lanes = 4'hf;
    logic [17:0] addr = 18'h0;
    logic order = 1'b0;
    logic slp = 1'b0;
    logic oe_n = 1'b1;
    logic drv = 1'b0;
    logic [35:0] wdat = 36'h0;
    logic [35:0] bus, dout, doe;
    logic [7:0] clash;
    int n_errors = 0;
    int cmp_count = 0;
    logic [35:0] mem [int];
    burst_sram_cycle_decode uut (.mclk(mclk), .nrst(nrst), .ctl(ctl), .byte_lane_select_n(lanes), .addr(addr),
        .burst_order(order), .sleep_request(slp), .output_enable_n(oe_n), .data_in(bus[31:0]),
        .data_out(dout[31:0]), .data_oe(doe[31:0]), .parity_io_in(bus[35:32]), .parity_io_out(dout[35:32]),
        .parity_io_oe(doe[35:32]));
    host_bus_model host (.mclk(mclk), .drv(drv), .wdat(wdat), .dout(dout), .doe(doe), .bus(bus), .clash(clash));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One bus cycle: set at a fall, sampled at the rise, outputs settled at the next fall
    task automatic cyc(input logic [7:0] c, input logic [17:0] a, input logic [3:0] ln, input logic [35:0] d);
        ctl = c;
        addr = a;
        lanes = ln;
        wdat = d;
        drv = c[4] & (!c[1] | (!c[0] & ln != 4'hf));
        @(negedge mclk);
    endtask : cyc
    function automatic logic [17:0] nth(input logic [17:0] b, input int k, input logic il);
        nth = b;
        nth[1:0] = il ? (b[1:0] ^ 2'(k)) : (b[1:0] + 2'(k));
    endfunction : nth
    task automatic t_write_read;
        oe_n = 1'b0;
        mem[16] = 36'h9_1234_5678;
        cyc(8'h55, 18'h10, 4'hf, mem[16]);
        chk("oe in write", 36'h0, doe);
        cyc(8'h4d, 18'h10, 4'hf, 36'h0);
        chk("read after write", mem[16], dout);
        chk("read drive", {36{1'b1}}, doe);
        oe_n = 1'b1;
        #1 chk("oe release", 36'h0, doe);
        @(negedge mclk);
        mem[16] = 36'h1_0000_0001;
        cyc(8'hfd, 18'h0, 4'hf, mem[16]);
        oe_n = 1'b0;
        cyc(8'hff, 18'h0, 4'hf, 36'h0);
        chk("hold write read", mem[16], dout);
    endtask : t_write_read
    task automatic t_burst(input logic il, input logic [17:0] b);
        order = il;
        oe_n = 1'b1;
        for (int k = 0; k < 4; k++) begin
            mem[int'(nth(b, k, il))] = {4'(k + 5), 14'h0, b};
            cyc(k == 0 ? 8'h55 : 8'hf9, b, 4'hf, {4'(k + 5), 14'h0, b});
        end
        oe_n = 1'b0;
        for (int k = 0; k < 4; k++) begin
            cyc(k == 0 ? 8'h4f : 8'hfb, b, 4'hf, 36'h0);
            chk("burst read", mem[int'(nth(b, k, il))], dout);
        end
        cyc(8'hff, b, 4'hf, 36'h0);
        chk("suspend read", mem[int'(nth(b, 3, il))], dout);
    endtask : t_burst
    task automatic t_lanes;
        logic [35:0] exp;
        exp = mem[16];
        for (int g = 0; g < 4; g++) begin
            if (g % 2 == 0) begin
                exp[g*8+:8] = 8'hd0 + 8'(g);
                exp[32+g] = 1'b0;
            end
        end
        oe_n = 1'b1;
        cyc(8'h56, 18'h10, 4'ha, 36'h0_d3d2_d1d0);
        oe_n = 1'b0;
        cyc(8'h56, 18'h10, 4'hf, 36'hf_ffff_ffff);
        chk("lane merge", exp, dout);
    endtask : t_lanes
    task automatic t_desel;
        cyc(8'h17, 18'h10, 4'hf, 36'h0);
        chk("depth deselect", 36'h0, doe);
        cyc(8'h4f, 18'h10, 4'hf, 36'h0);
        cyc(8'hd7, 18'h10, 4'hf, 36'h0);
        chk("primary deselect", 36'h0, doe);
    endtask : t_desel
    task automatic t_sleep;
        cyc(8'h4f, 18'h10, 4'hf, 36'h0);
        chk("before sleep", {36{1'b1}}, doe);
        slp = 1'b1;
        #1 chk("sleep float", 36'h0, doe);
        @(negedge mclk);
        cyc(8'h4f, 18'h10, 4'hf, 36'h0);
        chk("sleep start", 36'h0, doe);
        slp = 1'b0;
        repeat (3) cyc(8'hff, 18'h0, 4'hf, 36'h0);
        chk("after sleep", 36'h0, doe);
    endtask : t_sleep
    task automatic wrap_up;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        t_write_read();
        t_burst(1'b0, 18'h1);
        t_burst(1'b1, 18'h2);
        t_lanes();
        t_desel();
        t_sleep();
        chk("bus clash", 36'h0, {28'h0, clash});
        wrap_up();
    end
    initial begin
        #20000;
        n_errors++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
